//--- core/gpio_fault_routing.sv
// general pin output and input data plus fault output routing
// assumes a serial bus front end hands over decoded byte accesses,
// a boot loader writes nonvolatile values through the load port,
// and threshold flags arrive synchronous to i_mclk
`timescale 1ns/10ps

module gpio_fault_routing (
    input  wire logic        i_mclk,        // system clock, 100 MHz
    input  wire logic        i_rst_b,       // async reset, active low
    input  wire logic        i_reg_wr,      // register write strobe
    input  wire logic        i_reg_rd,      // register read strobe
    input  wire logic        i_reg_ext,     // 1 = extended page
    input  wire logic [7:0]  i_reg_addr,    // register offset
    input  wire logic [7:0]  i_reg_wdata,   // write data
    output logic      [7:0]  o_reg_rdata,   // read data
    output logic             o_reg_rvalid,  // read data valid pulse
    input  wire logic        i_nv_wr,       // boot load write strobe
    input  wire logic [7:0]  i_nv_addr,     // boot load offset
    input  wire logic [7:0]  i_nv_data,     // boot load data
    input  wire logic [11:0] i_mon_ov,      // overvoltage flags
    input  wire logic [11:0] i_mon_uv,      // undervoltage flags
    input  wire logic [11:0] i_mon_ew,      // early warning flags
    input  wire logic [5:0]  i_pin_in,      // general pins level in
    output logic      [5:0]  o_pin_out,     // general pins level out
    output logic      [5:0]  o_pin_oe,      // general pins drive enable
    output logic      [3:0]  o_sense_pd,    // strong pulldown enables
    output logic             o_margin       // margin mode active
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] fault_a_mask_low;
    logic [7:0] fault_a_mask_high_and_type;
    logic [7:0] fault_b_mask_low;
    logic [7:0] fault_b_mask_high_and_type;
    logic [7:0] pin_mode_0;
    logic [7:0] pin_mode_1;
    logic [7:0] pin_mode_2;
    logic [7:0] margin_ctrl;
    logic [7:0] pulldown_ctrl;
    logic [5:0] pin_output_levels;
    logic [5:0] pin_input_levels;
    logic       any_fault;
    logic [5:0] fault_lvl;
    logic       margin_now;
    logic [2:0] pin_mode [6];
    logic [7:0] next_rdata;
    logic       main_wr;
    logic [7:0] main_addr;
    logic [7:0] main_data;

    fault_cfg_if fault_a ();
    fault_cfg_if fault_b ();

    // pin mode field of one pin, fields straddle byte boundaries
    function automatic logic [2:0] mode_of(input int unsigned pin,
                                           input logic [7:0] m0,
                                           input logic [7:0] m1,
                                           input logic [7:0] m2);
        logic [23:0] all;
        all = {m2, m1, m0};
        mode_of = all[pin*3 +: 3];
    endfunction : mode_of

    // ------------------------------------------------------------
    // main page write path
    // ------------------------------------------------------------
    // boot load takes the port; extended page has no load path
    always_comb begin
        main_wr   = i_nv_wr | (i_reg_wr & ~i_reg_ext);
        main_addr = i_nv_wr ? i_nv_addr : i_reg_addr;
        main_data = i_nv_wr ? i_nv_data : i_reg_wdata;
    end

    // fault routing configuration
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fault_a_mask_low           <= gpio_fault_pkg::REG_RESET;
            fault_a_mask_high_and_type <= gpio_fault_pkg::REG_RESET;
            fault_b_mask_low           <= gpio_fault_pkg::REG_RESET;
            fault_b_mask_high_and_type <= gpio_fault_pkg::REG_RESET;
        end else if (main_wr) begin
            unique case (main_addr)
                gpio_fault_pkg::ADDR_FAULT_A_MASK_LOW:
                    fault_a_mask_low <= main_data;
                gpio_fault_pkg::ADDR_FAULT_A_MASK_HIGH:
                    fault_a_mask_high_and_type <= main_data;
                gpio_fault_pkg::ADDR_FAULT_B_MASK_LOW:
                    fault_b_mask_low <= main_data;
                gpio_fault_pkg::ADDR_FAULT_B_MASK_HIGH:
                    fault_b_mask_high_and_type <= main_data;
                default: ;
            endcase
        end
    end

    // pin mode, margin and pulldown control
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_mode_0    <= gpio_fault_pkg::REG_RESET;
            pin_mode_1    <= gpio_fault_pkg::REG_RESET;
            pin_mode_2    <= gpio_fault_pkg::REG_RESET;
            margin_ctrl   <= gpio_fault_pkg::REG_RESET;
            pulldown_ctrl <= gpio_fault_pkg::REG_RESET;
        end else if (main_wr) begin
            unique case (main_addr)
                gpio_fault_pkg::ADDR_PIN_MODE_0:    pin_mode_0 <= main_data;
                gpio_fault_pkg::ADDR_PIN_MODE_1:    pin_mode_1 <= main_data;
                gpio_fault_pkg::ADDR_PIN_MODE_2:    pin_mode_2 <= main_data;
                gpio_fault_pkg::ADDR_MARGIN_CTRL:   margin_ctrl <= main_data;
                gpio_fault_pkg::ADDR_PULLDOWN_CTRL: pulldown_ctrl <= main_data;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // extended page
    // ------------------------------------------------------------
    // output data, bus writes only; the input register has no writer
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_output_levels <= 6'h00;
        end else if (i_reg_wr && i_reg_ext &&
                     i_reg_addr == gpio_fault_pkg::ADDR_PIN_OUTPUT_LEVELS) begin
            pin_output_levels <= i_reg_wdata[5:0];
        end
    end

    // input levels sampled every cycle, writes to 1Bh fall through
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_input_levels <= 6'h00;
        end else begin
            pin_input_levels <= i_pin_in;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // unmapped offsets and the unused top bits of 1Ah and 1Bh read as zero
    always_comb begin
        next_rdata = 8'h00;
        if (i_reg_ext) begin
            unique case (i_reg_addr)
                gpio_fault_pkg::ADDR_PIN_OUTPUT_LEVELS:
                    next_rdata = {2'b00, pin_output_levels};
                gpio_fault_pkg::ADDR_PIN_INPUT_LEVELS:
                    next_rdata = {2'b00, pin_input_levels};
                default: ;
            endcase
        end else begin
            unique case (i_reg_addr)
                gpio_fault_pkg::ADDR_FAULT_A_MASK_LOW:
                    next_rdata = fault_a_mask_low;
                gpio_fault_pkg::ADDR_FAULT_A_MASK_HIGH:
                    next_rdata = fault_a_mask_high_and_type;
                gpio_fault_pkg::ADDR_FAULT_B_MASK_LOW:
                    next_rdata = fault_b_mask_low;
                gpio_fault_pkg::ADDR_FAULT_B_MASK_HIGH:
                    next_rdata = fault_b_mask_high_and_type;
                gpio_fault_pkg::ADDR_PIN_MODE_0:    next_rdata = pin_mode_0;
                gpio_fault_pkg::ADDR_PIN_MODE_1:    next_rdata = pin_mode_1;
                gpio_fault_pkg::ADDR_PIN_MODE_2:    next_rdata = pin_mode_2;
                gpio_fault_pkg::ADDR_MARGIN_CTRL:   next_rdata = margin_ctrl;
                gpio_fault_pkg::ADDR_PULLDOWN_CTRL: next_rdata = pulldown_ctrl;
                default: ;
            endcase
        end
    end

    // read answer one cycle after the strobe
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // margin and fault routing
    // ------------------------------------------------------------
    // margin pin is pin 6 in its sense mode, low active
    always_comb begin
        for (int p = 0; p < gpio_fault_pkg::PIN_COUNT; p++) begin
            pin_mode[p] = mode_of(p, pin_mode_0, pin_mode_1, pin_mode_2);
        end
        margin_now = margin_ctrl[gpio_fault_pkg::MARGIN_SW_BIT] |
                     (pin_mode[5] == gpio_fault_pkg::MODE_SENSE &
                      ~pin_input_levels[5]);
        fault_lvl  = {fault_b.level, fault_a.level, {4{~any_fault}}};
    end

    // masks, type enables and polarity handed to the routers
    always_comb begin
        fault_a.mask     = {fault_a_mask_high_and_type[3:0],
                            fault_a_mask_low};
        fault_a.type_en  = fault_a_mask_high_and_type[6:4];
        fault_a.polarity = fault_a_mask_high_and_type[
                               gpio_fault_pkg::POLARITY_BIT];
        fault_b.mask     = {fault_b_mask_high_and_type[3:0],
                            fault_b_mask_low};
        fault_b.type_en  = fault_b_mask_high_and_type[6:4];
        fault_b.polarity = fault_b_mask_high_and_type[
                               gpio_fault_pkg::POLARITY_BIT];
        fault_a.freeze   = margin_now;
        fault_b.freeze   = margin_now;
        fault_a.ov       = i_mon_ov;
        fault_a.uv       = i_mon_uv;
        fault_a.ew       = i_mon_ew;
        fault_b.ov       = i_mon_ov;
        fault_b.uv       = i_mon_uv;
        fault_b.ew       = i_mon_ew;
    end

    fault_router u_fault_a (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .cfg     (fault_a.router)
    );

    fault_router u_fault_b (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .cfg     (fault_b.router)
    );

    // any-fault: every input, every type, held during margin
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            any_fault <= 1'b0;
        end else if (!margin_now) begin
            any_fault <= |(i_mon_ov | i_mon_uv | i_mon_ew);
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    // registered so pins never glitch on mode decode
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pin_out <= 6'h00;
            o_pin_oe  <= 6'h00;
        end else begin
            for (int p = 0; p < gpio_fault_pkg::PIN_COUNT; p++) begin
                unique case (pin_mode[p])
                    gpio_fault_pkg::MODE_PP_LOGIC: begin
                        o_pin_out[p] <= pin_output_levels[p];
                        o_pin_oe[p]  <= 1'b1;
                    end
                    gpio_fault_pkg::MODE_OD_LOGIC: begin
                        o_pin_out[p] <= 1'b0;
                        o_pin_oe[p]  <= ~pin_output_levels[p];
                    end
                    gpio_fault_pkg::MODE_PP_FAULT: begin
                        o_pin_out[p] <= fault_lvl[p];
                        o_pin_oe[p]  <= 1'b1;
                    end
                    gpio_fault_pkg::MODE_OD_FAULT: begin
                        o_pin_out[p] <= 1'b0;
                        o_pin_oe[p]  <= ~fault_lvl[p];
                    end
                    default: begin
                        o_pin_out[p] <= 1'b0;
                        o_pin_oe[p]  <= 1'b0;
                    end
                endcase
            end
        end
    end

    // pulldowns and margin flag
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_sense_pd <= 4'h0;
            o_margin   <= 1'b0;
        end else begin
            o_sense_pd <= pulldown_ctrl[7:4];
            o_margin   <= margin_now;
        end
    end

endmodule : gpio_fault_routing

//--- core/gpio_fault_pkg.sv
// constants for the general pin data and fault routing block
// assumes the serial bus front end delivers decoded byte accesses
package gpio_fault_pkg;

    // ------------------------------------------------------------
    // register offsets, main page
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_FAULT_A_MASK_LOW  = 8'h15;
    localparam logic [7:0] ADDR_FAULT_A_MASK_HIGH = 8'h16;
    localparam logic [7:0] ADDR_FAULT_B_MASK_LOW  = 8'h17;
    localparam logic [7:0] ADDR_FAULT_B_MASK_HIGH = 8'h18;
    localparam logic [7:0] ADDR_PIN_MODE_0        = 8'h1C;
    localparam logic [7:0] ADDR_PIN_MODE_1        = 8'h1D;
    localparam logic [7:0] ADDR_PIN_MODE_2        = 8'h1E;
    localparam logic [7:0] ADDR_MARGIN_CTRL       = 8'h4D;
    localparam logic [7:0] ADDR_PULLDOWN_CTRL     = 8'h4E;

    // ------------------------------------------------------------
    // register offsets, extended page
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PIN_OUTPUT_LEVELS = 8'h1A;
    localparam logic [7:0] ADDR_PIN_INPUT_LEVELS  = 8'h1B;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         HIGH_MON_LSB    = 0;
    localparam int         TYPE_OV_BIT     = 4;
    localparam int         TYPE_UV_BIT     = 5;
    localparam int         TYPE_EW_BIT     = 6;
    localparam int         POLARITY_BIT    = 7;
    localparam int         MARGIN_SW_BIT   = 1;
    localparam int         PULLDOWN_LSB    = 4;
    localparam int         PIN_COUNT       = 6;
    localparam int         MON_COUNT       = 12;
    localparam logic [7:0] REG_RESET       = 8'h00;
    localparam logic [2:0] MODE_RESET      = 3'h0;

    // ------------------------------------------------------------
    // pin modes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_SENSE      = 3'h0;
    localparam logic [2:0] MODE_PP_LOGIC   = 3'h1;
    localparam logic [2:0] MODE_OD_LOGIC   = 3'h2;
    localparam logic [2:0] MODE_PP_FAULT   = 3'h3;
    localparam logic [2:0] MODE_OD_FAULT   = 3'h4;
    localparam logic [2:0] MODE_LOGIC_IN   = 3'h5;

endpackage : gpio_fault_pkg

//--- core/fault_cfg_if.sv
// carrier between the top block and one dedicated fault router
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface fault_cfg_if;
    logic [11:0] mask;      // monitor inputs selected
    logic [2:0]  type_en;   // ov, uv, ew enables
    logic        polarity;  // 1 = asserted high
    logic        freeze;    // margin mode hold
    logic [11:0] ov;        // overvoltage flags
    logic [11:0] uv;        // undervoltage flags
    logic [11:0] ew;        // early warning flags
    logic        level;     // logical output level

    modport cfg    (output mask, type_en, polarity, freeze, ov, uv, ew,
                    input level);
    modport router (input mask, type_en, polarity, freeze, ov, uv, ew,
                    output level);
endinterface : fault_cfg_if

//--- core/fault_router.sv
// one dedicated fault output: masked or of selected threshold types
// assumes violation flags are synchronous to i_mclk
`timescale 1ns/10ps
module fault_router (
    input  wire logic  i_mclk,   // system clock
    input  wire logic  i_rst_b,  // async reset, active low
    fault_cfg_if.router cfg      // configuration and level
);

    logic asserted;

    // ------------------------------------------------------------
    // cause decode
    // ------------------------------------------------------------
    // any selected input with any enabled type trips the output
    always_comb begin
        asserted = |(cfg.mask & ((cfg.ov & {12{cfg.type_en[0]}}) |
                                 (cfg.uv & {12{cfg.type_en[1]}}) |
                                 (cfg.ew & {12{cfg.type_en[2]}})));
    end

    // ------------------------------------------------------------
    // output level
    // ------------------------------------------------------------
    // held while margin mode is on so ramps cannot signal errors
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cfg.level <= 1'b1;
        end else if (!cfg.freeze) begin
            cfg.level <= cfg.polarity ? asserted : ~asserted;
        end
    end

endmodule : fault_router

//--- sim/gpio_fault_routing_sva.sv
// checker for the general pin data and fault routing block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
module gpio_fault_routing_sva (
    input wire logic        i_mclk,       // system clock
    input wire logic        i_rst_b,      // async reset, active low
    input wire logic        i_reg_wr,     // write strobe
    input wire logic        i_reg_rd,     // read strobe
    input wire logic        i_reg_ext,    // extended page
    input wire logic [7:0]  i_reg_addr,   // offset
    input wire logic [7:0]  i_reg_wdata,  // write data
    input wire logic [7:0]  o_reg_rdata,  // read data
    input wire logic        o_reg_rvalid, // read valid
    input wire logic        i_nv_wr,      // boot load strobe
    input wire logic [7:0]  i_nv_addr,    // boot load offset
    input wire logic [5:0]  i_pin_in,     // pin levels in
    input wire logic [5:0]  o_pin_out,    // pin levels out
    input wire logic [5:0]  o_pin_oe,     // pin drive enables
    input wire logic [3:0]  o_sense_pd,   // pulldown enables
    input wire logic        o_margin      // margin active
);
    // ----------------------------------------
    // helper state
    // ----------------------------------------
    logic [1:0] age;       // edges since reset, saturating
    logic       mode_set;  // some pin mode was written
    // input register is trusted only once three edges have passed since reset
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) age <= 2'h0;
        else if (age != 2'h3) age <= age + 2'h1;
    end
    // bus or boot writes into the mode bytes 1Ch..1Eh
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) mode_set <= 1'b0;
        else if ((i_reg_wr && !i_reg_ext && i_reg_addr >= 8'h1C
                  && i_reg_addr <= 8'h1E) || (i_nv_wr
                  && i_nv_addr >= 8'h1C && i_nv_addr <= 8'h1E))
            mode_set <= 1'b1;
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    sequence s_read;
        i_reg_rd;
    endsequence
    sequence s_wr_main(a);
        i_reg_wr && !i_reg_ext && !i_nv_wr && i_reg_addr == a;
    endsequence
    sequence s_quiet;
        o_margin && !i_reg_wr && !i_nv_wr;
    endsequence
    AST_READ_ANSWER: assert property (s_read |=> o_reg_rvalid)
        else $error("read got no valid pulse");
    AST_NO_SPURIOUS: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("valid pulse without read");
    AST_INPUT_LEVELS: assert property (s_read ##0 (i_reg_ext
        && i_reg_addr == 8'h1B && age == 2'h3 && $stable(i_pin_in))
        |=> o_reg_rdata == {2'h0, $past(i_pin_in)})
        else $error("input levels read wrong");
    AST_TOP_BITS: assert property (s_read ##0 (i_reg_ext
        && (i_reg_addr == 8'h1A || i_reg_addr == 8'h1B))
        |=> o_reg_rdata[7:6] == 2'h0)
        else $error("unused bits read nonzero");
    AST_PULLDOWN: assert property (s_wr_main(8'h4E)
        |=> ##1 o_sense_pd == $past(i_reg_wdata[7:4], 2))
        else $error("pulldown enables wrong");
    AST_MARGIN_ON: assert property (s_wr_main(8'h4D)
        ##0 i_reg_wdata[1] |=> ##1 o_margin)
        else $error("margin not entered");
    AST_IDLE_PINS: assert property (!mode_set |-> o_pin_oe == 6'h00)
        else $error("pin driven before any mode set");
    AST_FREEZE: assert property (s_quiet [*4]
        |-> $stable(o_pin_out) && $stable(o_pin_oe))
        else $error("pins moved during margin");
endmodule : gpio_fault_routing_sva

bind gpio_fault_routing gpio_fault_routing_sva u_sva (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_ext(i_reg_ext), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_nv_wr(i_nv_wr), .i_nv_addr(i_nv_addr),
    .i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
    .o_sense_pd(o_sense_pd), .o_margin(o_margin));

//--- sim/pin_load_model.sv
// board model of the six general pins
// assumes the block drives a pin only while its enable is high
`timescale 1ns/10ps
module pin_load_model (
    input  wire logic [5:0] i_drv_level, // level the block drives
    input  wire logic [5:0] i_drv_en,    // block drive enables
    input  wire logic [5:0] i_pull,      // board pull or outside source
    output logic      [5:0] o_pin        // resolved pin level
);
    // released pins fall to the board level, never keep a stale value
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            o_pin[i] = i_drv_en[i] ? i_drv_level[i] : i_pull[i];
        end
    end
endmodule : pin_load_model

//--- sim/gpio_fault_routing_tb.sv
// self-checking bench for the general pin and fault routing block
// assumes the pin board model loops driven levels back to the inputs
`timescale 1ns/10ps
module gpio_fault_routing_tb;
    logic        i_mclk = 1'b0, i_rst_b = 1'b0, i_reg_wr = 1'b0;
    logic        i_reg_rd = 1'b0, i_reg_ext = 1'b0, i_nv_wr = 1'b0;
    logic [7:0]  i_reg_addr = 8'h00, i_reg_wdata = 8'h00;
    logic [7:0]  i_nv_addr = 8'h00, i_nv_data = 8'h00, o_reg_rdata;
    logic [11:0] i_mon_ov = 12'h000, i_mon_uv = 12'h000, i_mon_ew = 12'h000;
    logic [5:0]  i_pin_in, o_pin_out, o_pin_oe, pull = 6'h3F, fexp;
    logic [3:0]  o_sense_pd;
    logic        o_reg_rvalid, o_margin;
    logic [7:0]  expq[$], d, mode_tab[3][3];
    logic [31:0] ma, mb;
    int          n_errors = 0, checks_done = 0, cyc = 0;

    gpio_fault_routing DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_ext(i_reg_ext),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
        .i_nv_wr(i_nv_wr), .i_nv_addr(i_nv_addr), .i_nv_data(i_nv_data),
        .i_mon_ov(i_mon_ov), .i_mon_uv(i_mon_uv), .i_mon_ew(i_mon_ew),
        .i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
        .o_sense_pd(o_sense_pd), .o_margin(o_margin));
    pin_load_model u_pins (.i_drv_level(o_pin_out), .i_drv_en(o_pin_oe),
        .i_pull(pull), .o_pin(i_pin_in));

    // ----------------------------------------
    // clock, timeout, closing
    // ----------------------------------------
    always #5 i_mclk = ~i_mclk;
    // a hang is cut short well past the expected few hundred cycles
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // monitor samples mid-cycle, away from the launching edge
    always @(negedge i_mclk) begin
        if (o_reg_rvalid === 1'b1) begin
            if (expq.size() == 0) check({7'h00, o_reg_rvalid}, 8'h00);
            else check(o_reg_rdata, expq.pop_front());
        end
    end

    // ----------------------------------------
    // bus driving
    // ----------------------------------------
    task automatic bus(input logic rd, input logic ext, input logic [7:0] a,
                       input logic [7:0] wd);
        @(posedge i_mclk);
        #1;
        {i_reg_rd, i_reg_wr, i_reg_ext, i_reg_addr, i_reg_wdata} =
            {rd, !rd, ext, a, wd};
        @(posedge i_mclk);
        #1;
        {i_reg_rd, i_reg_wr} = 2'b00;
    endtask : bus
    task automatic rd(input logic ext, input logic [7:0] a,
                      input logic [7:0] exp);
        expq.push_back(exp);
        bus(1'b1, ext, a, 8'h00);
    endtask : rd
    task automatic settle;
        repeat (4) @(posedge i_mclk);
        #1;
    endtask : settle
    // expected router level, cfg = {polarity, ew, uv, ov}
    function automatic logic rt(input logic [11:0] sel,
                                input logic [3:0] cfg);
        logic hit;
        hit = |(sel & ((i_mon_ov & {12{cfg[0]}}) | (i_mon_uv & {12{cfg[1]}})
                       | (i_mon_ew & {12{cfg[2]}})));
        return cfg[3] ? hit : !hit;
    endfunction : rt
    function automatic logic [5:0] fault_pins;
        return {rt({mb[11:8], mb[7:0]}, mb[15:12]),
                rt({ma[11:8], ma[7:0]}, ma[15:12]),
                {4{~|(i_mon_ov | i_mon_uv | i_mon_ew)}}};
    endfunction : fault_pins

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(33461));
        // rows: push-pull logic, open-drain logic, logic input
        mode_tab = '{'{8'h49, 8'h92, 8'h00}, '{8'h92, 8'h24, 8'h01},
                     '{8'h6D, 8'hDB, 8'h02}};
        repeat (16) @(posedge i_mclk);
        #1;
        i_rst_b = 1'b1;
        // reset values, unmapped offset reads zero
        for (int i = 0; i < 3; i++) rd(1'b0, 8'h1C + 8'(i), 8'h00);
        for (int a = 8'h15; a <= 8'h18; a++) rd(1'b0, 8'(a), 8'h00);
        rd(1'b0, 8'h60, 8'h00);
        rd(1'b1, 8'h1A, 8'h00);
        // boot load reaches the main page but never the extended one
        @(posedge i_mclk);
        #1;
        {i_nv_wr, i_nv_addr, i_nv_data} = {1'b1, 8'h1A, 8'hFF};
        @(posedge i_mclk);
        #1;
        {i_nv_addr, i_nv_data} = {8'h15, 8'hA5};
        @(posedge i_mclk);
        #1;
        i_nv_wr = 1'b0;
        rd(1'b1, 8'h1A, 8'h00);
        rd(1'b0, 8'h15, 8'hA5);
        // pulldown enables follow their field
        d = 8'($urandom);
        bus(1'b0, 1'b0, 8'h4E, d);
        settle();
        check({4'h0, o_sense_pd}, {4'h0, d[7:4]});
        // output data only reaches pins in logic output modes
        foreach (mode_tab[m]) begin
            for (int k = 0; k < 3; k++) bus(1'b0, 1'b0, 8'h1C + 8'(k),
                                            mode_tab[m][k]);
            repeat (3) begin
                d = 8'($urandom);
                if (m == 2) pull = 6'($urandom);
                bus(1'b0, 1'b1, 8'h1A, d);
                bus(1'b0, 1'b1, 8'h1B, ~d);
                settle();
                rd(1'b1, 8'h1B, {2'h0, (m < 2) ? d[5:0] : pull});
                rd(1'b1, 8'h1A, {2'h0, d[5:0]});
            end
        end
        pull = 6'h3F;
        // every pin as a push-pull fault output
        bus(1'b0, 1'b0, 8'h1C, 8'hDB);
        bus(1'b0, 1'b0, 8'h1D, 8'hB6);
        bus(1'b0, 1'b0, 8'h1E, 8'h01);
        for (int k = 0; k < 12; k++) begin
            ma = $urandom;
            mb = $urandom;
            bus(1'b0, 1'b0, 8'h15, ma[7:0]);
            bus(1'b0, 1'b0, 8'h16, ma[15:8]);
            bus(1'b0, 1'b0, 8'h17, mb[7:0]);
            bus(1'b0, 1'b0, 8'h18, mb[15:8]);
            i_mon_ov = (k % 3 == 0) ? 12'h000 : 12'($urandom & $urandom);
            i_mon_uv = (k % 3 == 0) ? 12'h000 : 12'($urandom & $urandom);
            i_mon_ew = (k % 3 == 0) ? 12'h000 : 12'($urandom & $urandom);
            settle();
            rd(1'b1, 8'h1B, {2'h0, fault_pins()});
        end
        // margin mode holds every fault output
        fexp = fault_pins();
        bus(1'b0, 1'b0, 8'h4D, 8'h02);
        i_mon_ov = ~i_mon_ov;
        i_mon_uv = 12'hFFF;
        settle();
        check({7'h00, o_margin}, 8'h01);
        rd(1'b1, 8'h1B, {2'h0, fexp});
        bus(1'b0, 1'b0, 8'h4D, 8'h00);
        settle();
        rd(1'b1, 8'h1B, {2'h0, fault_pins()});
        settle();
        complete_run();
    end
endmodule : gpio_fault_routing_tb
